//--- rtl/qudc_pkg.sv
package qudc_pkg;
	localparam int QUDC_AW = 8;
	localparam int QUDC_DW = 32;
	localparam int QUDC_CW = 16;
	localparam int QUDC_CTRL_W = 19;
	localparam int QUDC_NPIN = 5;

	localparam logic [7:0] QUDC_OFS_CTRL   = 8'h00;
	localparam logic [7:0] QUDC_OFS_CMP0   = 8'h04;
	localparam logic [7:0] QUDC_OFS_CMP1   = 8'h08;
	localparam logic [7:0] QUDC_OFS_CC0    = 8'h0C;
	localparam logic [7:0] QUDC_OFS_CC1    = 8'h10;
	localparam logic [7:0] QUDC_OFS_COUNT  = 8'h14;
	localparam logic [7:0] QUDC_OFS_STATUS = 8'h18;

	localparam int QUDC_B_MODE    = 0;
	localparam int QUDC_B_SUBMODE = 1;
	localparam int QUDC_B_SRC     = 2;
	localparam int QUDC_B_CLRLO   = 5;
	localparam int QUDC_B_CLRHI   = 6;
	localparam int QUDC_B_RELOAD  = 7;
	localparam int QUDC_B_ENABLE  = 8;
	localparam int QUDC_B_AEDGE   = 9;
	localparam int QUDC_B_BEDGE   = 11;
	localparam int QUDC_B_T0EDGE  = 13;
	localparam int QUDC_B_T1EDGE  = 15;
	localparam int QUDC_B_CC0CAP  = 17;
	localparam int QUDC_B_CC1CAP  = 18;

	localparam int QUDC_S_DIR = 0;
	localparam int QUDC_S_OVF = 1;
	localparam int QUDC_S_UDF = 2;

	localparam logic [QUDC_CTRL_W-1:0] QUDC_CTRL_RST = 19'h00000;
	localparam logic [15:0] QUDC_CNT_RST = 16'h0000;
	localparam logic [15:0] QUDC_CMP_RST = 16'h0000;
	localparam logic [15:0] QUDC_CNT_MAX = 16'hFFFF;
	localparam logic [15:0] QUDC_CNT_ZERO = 16'h0000;

	localparam logic [1:0] QUDC_EDGE_RISE = 2'h1;
	localparam logic [1:0] QUDC_EDGE_FALL = 2'h2;
	localparam logic [1:0] QUDC_EDGE_BOTH = 2'h3;

	typedef enum logic [2:0] {
		QUDC_SRC_OFF    = 3'b000,
		QUDC_SRC_LEVEL  = 3'b100,
		QUDC_SRC_SPLIT  = 3'b101,
		QUDC_SRC_SAMPLE = 3'b110,
		QUDC_SRC_QUAD   = 3'b111
	} qudc_src_e;
endpackage

//--- rtl/qudc_counter.sv
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module qudc_counter (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [qudc_pkg::QUDC_AW-1:0] paddr,
	input  wire logic [qudc_pkg::QUDC_DW-1:0] pwdata,
	output logic      [qudc_pkg::QUDC_DW-1:0] prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        count_input_pin,
	input  wire logic                        direction_input_pin,
	input  wire logic                        external_clear_pin,
	input  wire logic                        capture_trigger_zero,
	input  wire logic                        capture_trigger_one,
	output logic                             compare_zero_irq,
	output logic                             compare_one_irq,
	output logic                             capcomp_zero_irq,
	output logic                             capcomp_one_irq,
	output logic                             direction_flag,
	output logic      [qudc_pkg::QUDC_CW-1:0] count_value
);
	import qudc_pkg::*;

	logic [QUDC_CTRL_W-1:0] ctrl_r;
	logic [QUDC_CW-1:0]     cmp0_r;
	logic [QUDC_CW-1:0]     cmp1_r;
	logic [QUDC_CW-1:0]     cc_r [2];
	logic [QUDC_CW-1:0]     cnt_r;
	logic [QUDC_CW-1:0]     cnt_nxt;
	logic                   dir_r;
	logic                   dir_nxt;
	logic                   ovf_r;
	logic                   udf_r;
	logic                   ovf_ev;
	logic                   udf_ev;
	logic [QUDC_NPIN-1:0]   pin_in;
	logic [QUDC_NPIN-1:0]   sync1_r;
	logic [QUDC_NPIN-1:0]   sync2_r;
	logic [QUDC_NPIN-1:0]   prev_r;
	logic                   wr_acc;
	logic                   rd_acc;
	logic                   addr_ok;
	logic                   mode_udc;
	logic                   run;
	logic                   submode_b;
	qudc_src_e              src;
	logic                   a_hit;
	logic                   b_hit;
	logic                   a_chg;
	logic                   b_chg;
	logic                   b_lvl;
	logic                   step_up;
	logic                   step_dn;
	logic                   cnt_ev;
	logic                   m0;
	logic                   m1;
	logic                   clr_ext;
	logic                   clr_cmp;
	logic                   ext_clr;
	logic                   sw_cnt_wr;
	logic [1:0]             trig_hit;
	logic [1:0]             cc_cap;
	logic [1:0]             cc_irq_nxt;

	function automatic logic edge_hit(input logic prev, input logic cur,
		input logic [1:0] sel);
		logic rise;
		logic fall;
		rise = cur & ~prev;
		fall = prev & ~cur;
		case (sel)
			QUDC_EDGE_RISE: edge_hit = rise;
			QUDC_EDGE_FALL: edge_hit = fall;
			QUDC_EDGE_BOTH: edge_hit = rise | fall;
			default:        edge_hit = 1'b0;
		endcase
	endfunction

	// APB slave with zero wait states; unmapped addresses raise pslverr.
	assign pready = 1'b1;
	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & penable & ~pwrite;
	always_comb begin
		case (paddr)
			QUDC_OFS_CTRL, QUDC_OFS_CMP0, QUDC_OFS_CMP1, QUDC_OFS_CC0,
			QUDC_OFS_CC1, QUDC_OFS_COUNT, QUDC_OFS_STATUS: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end
	assign pslverr = psel & penable & ~addr_ok;

	always_comb begin
		prdata = '0;
		case (paddr)
			QUDC_OFS_CTRL:   prdata[QUDC_CTRL_W-1:0] = ctrl_r;
			QUDC_OFS_CMP0:   prdata[QUDC_CW-1:0] = cmp0_r;
			QUDC_OFS_CMP1:   prdata[QUDC_CW-1:0] = cmp1_r;
			QUDC_OFS_CC0:    prdata[QUDC_CW-1:0] = cc_r[0];
			QUDC_OFS_CC1:    prdata[QUDC_CW-1:0] = cc_r[1];
			QUDC_OFS_COUNT:  prdata[QUDC_CW-1:0] = cnt_r;
			QUDC_OFS_STATUS: begin
				prdata[QUDC_S_DIR] = direction_flag;
				prdata[QUDC_S_OVF] = ovf_r;
				prdata[QUDC_S_UDF] = udf_r;
			end
			default:         prdata = '0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= QUDC_CTRL_RST;
			cmp0_r <= QUDC_CMP_RST;
			cmp1_r <= QUDC_CMP_RST;
		end else if (wr_acc) begin
			case (paddr)
				QUDC_OFS_CTRL: ctrl_r <= pwdata[QUDC_CTRL_W-1:0];
				QUDC_OFS_CMP0: cmp0_r <= pwdata[QUDC_CW-1:0];
				QUDC_OFS_CMP1: cmp1_r <= pwdata[QUDC_CW-1:0];
				default: ;
			endcase
		end
	end

	assign mode_udc  = ctrl_r[QUDC_B_MODE];
	assign run       = mode_udc & ctrl_r[QUDC_B_ENABLE];
	assign submode_b = ctrl_r[QUDC_B_SUBMODE];
	assign src       = qudc_src_e'(ctrl_r[QUDC_B_SRC +: 3]);
	assign clr_ext   = ctrl_r[QUDC_B_CLRLO];
	assign clr_cmp   = ctrl_r[QUDC_B_CLRHI];
	assign cc_cap    = {ctrl_r[QUDC_B_CC1CAP], ctrl_r[QUDC_B_CC0CAP]};

	// Two-stage synchronisers, then a third stage for edge detection.
	assign pin_in = {capture_trigger_one, capture_trigger_zero,
		external_clear_pin, direction_input_pin, count_input_pin};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= '0;
			sync2_r <= '0;
			prev_r  <= '0;
		end else begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	assign a_hit = edge_hit(prev_r[0], sync2_r[0], ctrl_r[QUDC_B_AEDGE +: 2]);
	assign b_hit = edge_hit(prev_r[1], sync2_r[1], ctrl_r[QUDC_B_BEDGE +: 2]);
	assign a_chg = prev_r[0] ^ sync2_r[0];
	assign b_chg = prev_r[1] ^ sync2_r[1];
	assign b_lvl = sync2_r[1];
	assign trig_hit[0] = edge_hit(prev_r[3], sync2_r[3],
		ctrl_r[QUDC_B_T0EDGE +: 2]);
	assign trig_hit[1] = edge_hit(prev_r[4], sync2_r[4],
		ctrl_r[QUDC_B_T1EDGE +: 2]);

	// Step decode per count source.
	always_comb begin
		step_up = 1'b0;
		step_dn = 1'b0;
		case (src)
			QUDC_SRC_LEVEL: begin
				if (a_hit) begin
					step_dn = b_lvl;
					step_up = ~b_lvl;
				end
			end
			QUDC_SRC_SPLIT: begin
				step_up = a_hit & ~b_hit;
				step_dn = b_hit & ~a_hit;
			end
			QUDC_SRC_SAMPLE: begin
				if (a_hit) begin
					step_up = b_lvl;
					step_dn = ~b_lvl;
				end
			end
			QUDC_SRC_QUAD: begin
				// Raw changes of both phases; edge selections play no part.
				if (a_chg && b_chg) begin
					step_dn = dir_r;
					step_up = ~dir_r;
				end else if (a_chg) begin
					step_up = sync2_r[0] != sync2_r[1];
					step_dn = sync2_r[0] == sync2_r[1];
				end else if (b_chg) begin
					step_up = sync2_r[0] == sync2_r[1];
					step_dn = sync2_r[0] != sync2_r[1];
				end
			end
			default: begin
				step_up = 1'b0;
				step_dn = 1'b0;
			end
		endcase
		if (!run) begin
			step_up = 1'b0;
			step_dn = 1'b0;
		end
	end

	assign cnt_ev    = step_up | step_dn;
	assign m0        = cnt_r == cmp0_r;
	assign m1        = cnt_r == cmp1_r;
	assign ext_clr   = run & ~submode_b & clr_ext & sync2_r[2] & ~prev_r[2];
	assign sw_cnt_wr = wr_acc & (paddr == QUDC_OFS_COUNT);

	// Next counter value: software write, then external clear, then count.
	always_comb begin
		cnt_nxt = cnt_r;
		ovf_ev  = 1'b0;
		udf_ev  = 1'b0;
		if (cnt_ev) begin
			if (!submode_b && step_up && m0 && clr_cmp) begin
				cnt_nxt = QUDC_CNT_ZERO;
			end else if (!submode_b && step_dn && cnt_r == QUDC_CNT_ZERO &&
				ctrl_r[QUDC_B_RELOAD]) begin
				cnt_nxt = cmp0_r;
				udf_ev  = 1'b1;
			end else if (submode_b && step_up && m0) begin
				cnt_nxt = QUDC_CNT_ZERO;
			end else if (submode_b && step_dn && m1) begin
				cnt_nxt = QUDC_CNT_ZERO;
			end else if (step_up) begin
				cnt_nxt = cnt_r + 16'h0001;
				ovf_ev  = cnt_r == QUDC_CNT_MAX;
			end else begin
				cnt_nxt = cnt_r - 16'h0001;
				udf_ev  = cnt_r == QUDC_CNT_ZERO;
			end
		end
		if (ext_clr) begin
			cnt_nxt = QUDC_CNT_ZERO;
		end
		if (sw_cnt_wr) begin
			cnt_nxt = pwdata[QUDC_CW-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= QUDC_CNT_RST;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// Direction follows the last step and is refreshed every clock.
	assign dir_nxt = step_dn ? 1'b1 : (step_up ? 1'b0 : dir_r);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_r <= 1'b0;
		end else begin
			dir_r <= dir_nxt;
		end
	end
	assign direction_flag = mode_udc & dir_r;
	assign count_value    = cnt_r;

	// Overflow and underflow flags clear on a status read; a new event wins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_r <= 1'b0;
			udf_r <= 1'b0;
		end else begin
			if (ovf_ev) begin
				ovf_r <= 1'b1;
			end else if (rd_acc && paddr == QUDC_OFS_STATUS) begin
				ovf_r <= 1'b0;
			end
			if (udf_ev) begin
				udf_r <= 1'b1;
			end else if (rd_acc && paddr == QUDC_OFS_STATUS) begin
				udf_r <= 1'b0;
			end
		end
	end

	// Capture/compare channels.
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_cc
			localparam logic [7:0] OFS = gi ? QUDC_OFS_CC1 : QUDC_OFS_CC0;
			assign cc_irq_nxt[gi] = cc_cap[gi] ? trig_hit[gi]
				: (cnt_ev && cnt_r == cc_r[gi]);
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cc_r[gi] <= QUDC_CMP_RST;
				end else if (cc_cap[gi] && trig_hit[gi]) begin
					cc_r[gi] <= cnt_r;
				end else if (wr_acc && paddr == OFS) begin
					cc_r[gi] <= pwdata[QUDC_CW-1:0];
				end
			end
		end
	endgenerate

	// Match interrupts are pulses at the count after equality.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_zero_irq <= 1'b0;
			compare_one_irq  <= 1'b0;
			capcomp_zero_irq <= 1'b0;
			capcomp_one_irq  <= 1'b0;
		end else begin
			compare_zero_irq <= cnt_ev & m0 & (~submode_b | step_up);
			compare_one_irq  <= cnt_ev & m1 & (~submode_b | step_dn);
			capcomp_zero_irq <= cc_irq_nxt[0];
			capcomp_one_irq  <= cc_irq_nxt[1];
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_off_no_count: assert property (
		(!run && !sw_cnt_wr) |=> (cnt_r == $past(cnt_r)))
		else $error("Counter moved while not in running up/down mode.");
	a_level_dir: assert property (
		(run && src == QUDC_SRC_LEVEL && a_hit) |-> (step_dn == b_lvl))
		else $error("Level mode counted in the wrong direction.");
	a_split_up: assert property (
		(run && src == QUDC_SRC_SPLIT && a_hit && !b_hit) |-> step_up)
		else $error("Split mode missed an up step.");
	a_split_down: assert property (
		(run && src == QUDC_SRC_SPLIT && b_hit && !a_hit) |-> step_dn)
		else $error("Split mode missed a down step.");
	a_split_hold: assert property (
		(run && src == QUDC_SRC_SPLIT && a_hit && b_hit && !sw_cnt_wr)
		|=> (cnt_r == $past(cnt_r)))
		else $error("Split mode counted on simultaneous edges.");
	a_sample_dir: assert property (
		(run && src == QUDC_SRC_SAMPLE && a_hit) |-> (step_up == b_lvl))
		else $error("Sample mode counted in the wrong direction.");
	a_quad_keep_dir: assert property (
		(run && src == QUDC_SRC_QUAD && a_chg && b_chg)
		|=> (dir_r == $past(dir_r)))
		else $error("Quadrature simultaneous edges changed direction.");
	a_modeb_clear: assert property (
		(run && submode_b && step_up && m0 && !sw_cnt_wr)
		|=> (cnt_r == QUDC_CNT_ZERO && compare_zero_irq))
		else $error("Sub-mode B did not clear on compare-zero.");
	a_modeb_down1: assert property (
		(run && submode_b && step_dn && m1 && !sw_cnt_wr)
		|=> (cnt_r == QUDC_CNT_ZERO && compare_one_irq))
		else $error("Sub-mode B did not clear on compare-one.");
	a_reload_cmp: assert property (
		(!submode_b && ctrl_r[QUDC_B_RELOAD] && step_dn && !sw_cnt_wr &&
		!ext_clr && cnt_r == QUDC_CNT_ZERO) |=> (cnt_r == $past(cmp0_r)))
		else $error("Reload of compare-zero value missing.");
	a_irq_late: assert property (
		compare_zero_irq |-> ($past(cnt_ev) && $past(m0)))
		else $error("Compare-zero interrupt without a preceding count.");
	a_dir_fixed: assert property (
		!mode_udc |-> !direction_flag)
		else $error("Direction flag set outside up/down mode.");
	a_capture_latch: assert property (
		(cc_cap[0] && trig_hit[0])
		|=> (cc_r[0] == $past(cnt_r) && capcomp_zero_irq))
		else $error("Capture channel zero failed to latch.");

	c_quad_up: cover property (run && src == QUDC_SRC_QUAD && step_up);
	c_quad_down: cover property (run && src == QUDC_SRC_QUAD && step_dn);
	c_modeb_clear: cover property (run && submode_b && step_dn && m1);
	c_reload: cover property (udf_ev && !submode_b);
	c_capture_one: cover property (cc_cap[1] && trig_hit[1]);
endmodule

//--- bench/qudc_encoder.sv
`timescale 1ns/1ps
module qudc_encoder (
	input  wire logic pclk,
	output logic      count_input_pin,
	output logic      direction_input_pin
);
	logic [1:0] st_r = 2'h0;

	// Phase position in Gray order; forward turning makes phase A lead B.
	assign count_input_pin     = st_r[1] ^ st_r[0];
	assign direction_input_pin = st_r[1];

	task automatic hold(input int gap);
		repeat (gap) @(posedge pclk);
	endtask

	task automatic step(input bit fwd, input int gap);
		@(posedge pclk);
		st_r <= fwd ? st_r + 2'h1 : st_r - 2'h1;
		hold(gap);
	endtask

	// Both phases move in the same cycle.
	task automatic jump(input int gap);
		@(posedge pclk);
		st_r <= st_r + 2'h2;
		hold(gap);
	endtask

	task automatic set(input logic a, input logic b, input int gap);
		@(posedge pclk);
		st_r <= {b, a ^ b};
		hold(gap);
	endtask
endmodule

//--- bench/quadrature_updown_counter_bench.sv
`timescale 1ns/1ps
module quadrature_updown_counter_bench;
	import qudc_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic        pready, pslverr, e;
	logic        ain, bin, clr_pin, trg0, trg1;
	logic [3:0]  irqs;
	logic        dir_flag;
	logic [15:0] cnt;
	int          failures, tests_run;
	int          n_irq [4] = '{default: 0};
	int          b [4];

	qudc_counter i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .count_input_pin(ain),
		.direction_input_pin(bin), .external_clear_pin(clr_pin),
		.capture_trigger_zero(trg0), .capture_trigger_one(trg1),
		.compare_zero_irq(irqs[0]), .compare_one_irq(irqs[1]),
		.capcomp_zero_irq(irqs[2]), .capcomp_one_irq(irqs[3]),
		.direction_flag(dir_flag), .count_value(cnt)
	);
	qudc_encoder i_enc (
		.pclk(pclk), .count_input_pin(ain), .direction_input_pin(bin)
	);

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Interrupt pulses are counted so scenarios can check how many fired.
	always @(posedge pclk) begin
		for (int i = 0; i < 4; i++) begin
			if (irqs[i] === 1'b1) begin
				n_irq[i] <= n_irq[i] + 1;
			end
		end
	end

	task complete_run;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		tests_run++;
		if (got !== ex) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rd(input string nm, input logic [7:0] a, input logic [31:0] ex);
		apb(1'b0, a, 32'h0);
		chk(nm, ex, q);
	endtask
	task cc(input logic [15:0] ex);
		chk("count_value", {16'h0000, ex}, {16'h0000, cnt});
	endtask
	task dl(input string nm, input int k, input int ex);
		chk(nm, ex, n_irq[k] - b[k]);
	endtask
	// Selector 0 pulses the clear pin, 1 trigger zero, 2 trigger one.
	task pulse(input int sel);
		@(posedge pclk);
		clr_pin <= (sel == 0);
		trg0 <= (sel == 1);
		trg1 <= (sel == 2);
		repeat (3) @(posedge pclk);
		trg0 <= 1'b0;
		trg1 <= 1'b0;
		clr_pin <= 1'b0;
		repeat (6) @(posedge pclk);
	endtask

	initial begin
		#100000;
		failures++;
		complete_run;
	end

	initial begin
		{presetn, psel, penable, pwrite, clr_pin, trg0, trg1} = 7'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd("ctrl", QUDC_OFS_CTRL, 32'h0);
		rd("count", QUDC_OFS_COUNT, 32'h0);
		apb(1'b0, 8'h1C, 32'h0);
		chk("pslverr", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
		wr(QUDC_OFS_CTRL, 32'h0000011C);
		repeat (4) i_enc.step(1, 6);
		cc(16'h0000);
		chk("dir off", 32'h0, {31'h0, dir_flag});
		wr(QUDC_OFS_CTRL, 32'h0000011D);
		wr(QUDC_OFS_COUNT, 32'h0);
		repeat (8) i_enc.step(1, 2);
		i_enc.hold(6);
		cc(16'h0008);
		chk("dir up", 32'h0, {31'h0, dir_flag});
		repeat (3) i_enc.step(0, 6);
		cc(16'h0005);
		chk("dir down", 32'h1, {31'h0, dir_flag});
		rd("status", QUDC_OFS_STATUS, 32'h1);
		i_enc.jump(6);
		cc(16'h0004);
		i_enc.step(1, 6);
		i_enc.jump(6);
		cc(16'h0006);
		wr(QUDC_OFS_CTRL, 32'h00000311);
		i_enc.set(0, 1, 6);
		wr(QUDC_OFS_COUNT, 32'hA);
		i_enc.set(1, 1, 6);
		cc(16'h0009);
		i_enc.set(0, 0, 6);
		i_enc.set(1, 0, 6);
		cc(16'h000A);
		wr(QUDC_OFS_CTRL, 32'h00000B15);
		i_enc.set(0, 0, 6);
		wr(QUDC_OFS_COUNT, 32'hA);
		i_enc.set(1, 0, 6);
		cc(16'h000B);
		i_enc.set(0, 0, 6);
		i_enc.set(0, 1, 6);
		cc(16'h000A);
		i_enc.set(0, 0, 6);
		i_enc.set(1, 1, 6);
		cc(16'h000A);
		wr(QUDC_OFS_CTRL, 32'h00000319);
		i_enc.set(0, 1, 6);
		wr(QUDC_OFS_COUNT, 32'hA);
		i_enc.set(1, 1, 6);
		cc(16'h000B);
		i_enc.set(0, 0, 6);
		i_enc.set(1, 0, 6);
		cc(16'h000A);
		i_enc.set(0, 0, 6);
		wr(QUDC_OFS_CMP0, 32'h3);
		wr(QUDC_OFS_CTRL, 32'h0000015D);
		wr(QUDC_OFS_COUNT, 32'h0);
		b = n_irq;
		repeat (4) i_enc.step(1, 6);
		cc(16'h0000);
		dl("cmp0 irq", 0, 1);
		wr(QUDC_OFS_CMP0, 32'h5);
		wr(QUDC_OFS_CTRL, 32'h0000019D);
		wr(QUDC_OFS_COUNT, 32'h1);
		repeat (2) i_enc.step(0, 6);
		cc(16'h0005);
		rd("status udf", QUDC_OFS_STATUS, 32'h5);
		rd("status clr", QUDC_OFS_STATUS, 32'h1);
		wr(QUDC_OFS_CTRL, 32'h0000013D);
		wr(QUDC_OFS_COUNT, 32'h1234);
		pulse(0);
		cc(16'h0000);
		wr(QUDC_OFS_CMP0, 32'h4);
		wr(QUDC_OFS_CMP1, 32'h2);
		wr(QUDC_OFS_CTRL, 32'h0000011F);
		wr(QUDC_OFS_COUNT, 32'h3);
		b = n_irq;
		repeat (2) i_enc.step(1, 6);
		cc(16'h0000);
		dl("cmp0 irq", 0, 1);
		wr(QUDC_OFS_COUNT, 32'h3);
		b = n_irq;
		repeat (2) i_enc.step(0, 6);
		cc(16'h0000);
		dl("cmp1 irq", 1, 1);
		wr(QUDC_OFS_COUNT, 32'h6);
		b = n_irq;
		repeat (3) i_enc.step(0, 6);
		cc(16'h0003);
		dl("cmp0 irq", 0, 0);
		wr(QUDC_OFS_COUNT, 32'h1);
		b = n_irq;
		repeat (2) i_enc.step(1, 6);
		dl("cmp1 irq", 1, 0);
		wr(QUDC_OFS_CC1, 32'h2);
		wr(QUDC_OFS_CTRL, 32'h0002211D);
		wr(QUDC_OFS_COUNT, 32'hABC);
		b = n_irq;
		pulse(1);
		rd("capture", QUDC_OFS_CC0, 32'hABC);
		dl("cap irq", 2, 1);
		wr(QUDC_OFS_COUNT, 32'h1);
		b = n_irq;
		repeat (2) i_enc.step(1, 6);
		dl("cc1 irq", 3, 1);
		wr(QUDC_OFS_CTRL, 32'h0004811D);
		wr(QUDC_OFS_COUNT, 32'h5A5);
		b = n_irq;
		pulse(2);
		rd("capture one", QUDC_OFS_CC1, 32'h5A5);
		dl("cap1 irq", 3, 1);
		complete_run;
	end
endmodule
